//--- logic/home_return_count_sequencer.sv
// home-return sequencer: stopper three, count one and count two methods
// assumes pin inputs are asynchronous and start is a core_clk pulse
`timescale 1ns/1ps
`default_nettype none
module home_return_count_sequencer #(
	parameter int unsigned CLEAR_CYCLES = home_return_pkg::CLEAR_CYCLES_DEF
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic homeStartInstruction,
	input wire home_return_pkg::method_e methodSel,
	input wire logic limitsSelected,
	input wire logic homeDirection,
	input wire logic [home_return_pkg::SPEED_W-1:0] searchSpeed,
	input wire logic [home_return_pkg::SPEED_W-1:0] creepSpeed,
	input wire logic [home_return_pkg::SPEED_W-1:0] biasSpeed,
	input wire logic [home_return_pkg::SPEED_W-1:0] accelStep,
	input wire logic [home_return_pkg::SPEED_W-1:0] stopDecelStep,
	input wire logic [home_return_pkg::DIST_W-1:0] postDogDistance,
	input wire logic cpuRun,
	input wire logic dogIn,
	input wire logic zeroIn,
	input wire logic limitHomeIn,
	input wire logic limitOppIn,
	input wire logic driveReadyIn,
	output logic pulseOut,
	output logic directionOut,
	output logic deviationClear,
	output logic homeDoneFlag,
	output logic homeRequestFlag,
	output logic busy,
	output logic strokeStop,
	output logic [15:0] errorCode
);
	import home_return_pkg::*;

	// ==========================================================
	// pin synchronisers; first stage read only by the second
	logic [5:0] pinMeta_reg, pinSync_reg;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= {cpuRun, driveReadyIn, limitOppIn, limitHomeIn, zeroIn, dogIn};
			pinSync_reg <= pinMeta_reg;
		end
	end
	logic dog, zero, limitHomeOk, limitOppOk, driveReady, runSync;
	assign {runSync, driveReady, limitOppOk, limitHomeOk, zero, dog} = pinSync_reg;

	// edge history for ready loss and stop-to-run
	logic driveReadyOld_reg, runOld_reg;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			driveReadyOld_reg <= 1'b0;
			runOld_reg <= 1'b0;
		end else begin
			driveReadyOld_reg <= driveReady;
			runOld_reg <= runSync;
		end
	end

	// ==========================================================
	// ramp generator
	motion_if mot ();
	speed_ramp u_ramp (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.m(mot)
	);

	// ==========================================================
	// state and working registers
	state_e state_reg, state_next;
	method_e method_reg;
	logic retryBack_reg;
	logic reverse_reg;
	logic [DIST_W-1:0] dist_reg;
	logic [31:0] clearCnt_reg;

	logic startOk, zeroRefused, isCount, moving, oppTrip, homeTrip, distDone, clearDone;
	assign startOk = homeStartInstruction && (state_reg == ST_IDLE);
	assign zeroRefused = startOk && (methodSel == METHOD_STOPPER3) && zero;
	assign isCount = (method_reg != METHOD_STOPPER3);
	assign moving = (state_reg == ST_SEARCH) || (state_reg == ST_SLOW) ||
		(state_reg == ST_WAIT_ZERO) || (state_reg == ST_CREEP3) ||
		(state_reg == ST_RETRY_REV);
	assign oppTrip = limitsSelected && !limitOppOk && moving;
	assign homeTrip = limitsSelected && !limitHomeOk && isCount;
	assign distDone = (dist_reg >= postDogDistance);
	assign clearDone = (clearCnt_reg == CLEAR_CYCLES - 1);

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (startOk && !zeroRefused) begin
					if (methodSel == METHOD_STOPPER3) state_next = ST_CREEP3;
					else if (dog) state_next = ST_RETRY_REV;
					else state_next = ST_SEARCH;
				end
			end
			ST_CREEP3: begin
				if (oppTrip) state_next = ST_STROKE_STOP;
				else if (zero) state_next = ST_CLEAR;
			end
			ST_SEARCH: begin
				if (oppTrip) state_next = ST_STROKE_STOP;
				else if (homeTrip) state_next = ST_RETRY_STOP;
				else if (dog) state_next = ST_SLOW;
			end
			ST_SLOW: begin
				if (oppTrip) state_next = ST_STROKE_STOP;
				else if (distDone && method_reg == METHOD_COUNT2) state_next = ST_DECEL_STOP;
				else if (distDone) state_next = ST_WAIT_ZERO;
			end
			ST_WAIT_ZERO: begin
				if (oppTrip) state_next = ST_STROKE_STOP;
				else if (zero) state_next = ST_CLEAR;
			end
			ST_CLEAR: begin
				if (clearDone) state_next = ST_IDLE;
			end
			ST_DECEL_STOP: begin
				if (mot.stopped) state_next = ST_IDLE;
			end
			ST_RETRY_STOP: begin
				if (mot.stopped) state_next = retryBack_reg ? ST_SEARCH : ST_RETRY_REV;
			end
			ST_RETRY_REV: begin
				// reverse until the dog has been passed, then come back
				if (oppTrip) state_next = ST_STROKE_STOP;
				else if (retryBack_reg && !dog) state_next = ST_RETRY_STOP;
			end
			ST_STROKE_STOP: begin
				if (mot.stopped) state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// ==========================================================
	// state register and method latch
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			method_reg <= METHOD_STOPPER3;
		end else begin
			state_reg <= state_next;
			if (startOk) method_reg <= methodSel;
		end
	end

	// retry bookkeeping: retryBack set once the dog is seen while reversing
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			retryBack_reg <= 1'b0;
			reverse_reg <= 1'b0;
		end else if (state_reg == ST_IDLE) begin
			retryBack_reg <= 1'b0;
			reverse_reg <= startOk && methodSel != METHOD_STOPPER3 && dog;
		end else if (state_reg == ST_RETRY_REV) begin
			reverse_reg <= 1'b1;
			if (dog) retryBack_reg <= 1'b1;
		end else if (state_reg == ST_RETRY_STOP && mot.stopped) begin
			reverse_reg <= !retryBack_reg;
		end
	end

	// post-dog travel counted in output pulses
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) dist_reg <= '0;
		else if (state_reg != ST_SLOW) dist_reg <= '0;
		else if (mot.pulse) dist_reg <= dist_reg + DIST_W'(1);
	end

	// clear pulse timer; width fixed whatever the speed was
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) clearCnt_reg <= '0;
		else if (state_reg != ST_CLEAR) clearCnt_reg <= '0;
		else clearCnt_reg <= clearCnt_reg + 32'h1;
	end

	// ==========================================================
	// motion command; zero past the distance halts at once even mid-slowdown
	logic haltNow;
	assign haltNow = (state_reg == ST_CLEAR) || (state_reg == ST_IDLE) ||
		(state_reg == ST_DECEL_STOP && mot.speed > creepSpeed);
	always_comb begin
		mot.targetSpeed = '0;
		case (state_reg)
			ST_SEARCH: mot.targetSpeed = searchSpeed;
			ST_RETRY_REV: mot.targetSpeed = searchSpeed;
			ST_CREEP3: mot.targetSpeed = creepSpeed;
			ST_SLOW: mot.targetSpeed = creepSpeed;
			ST_WAIT_ZERO: mot.targetSpeed = creepSpeed;
			default: mot.targetSpeed = '0;
		endcase
	end
	assign mot.biasSpeed = biasSpeed;
	assign mot.accelStep = accelStep;
	assign mot.decelStep = (state_reg == ST_DECEL_STOP) ? stopDecelStep : accelStep;
	assign mot.direction = homeDirection ^ reverse_reg;
	assign mot.halt = haltNow;

	// ==========================================================
	// flags; request set wins over any clear in the same cycle
	logic reqSet, doneSet;
	assign reqSet = startOk || (driveReadyOld_reg && !driveReady) ||
		(runSync && !runOld_reg);
	assign doneSet = (state_reg == ST_CLEAR && clearDone) ||
		(state_reg == ST_DECEL_STOP && mot.stopped);
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			homeRequestFlag <= 1'b1;
			homeDoneFlag <= 1'b0;
			errorCode <= ERR_NONE;
			strokeStop <= 1'b0;
			deviationClear <= 1'b0;
			pulseOut <= 1'b0;
			directionOut <= 1'b0;
		end else begin
			if (reqSet) homeRequestFlag <= 1'b1;
			else if (doneSet) homeRequestFlag <= 1'b0;
			if (startOk) homeDoneFlag <= 1'b0;
			else if (doneSet) homeDoneFlag <= 1'b1;
			if (zeroRefused) errorCode <= ERR_ZERO_ON;
			else if (startOk) errorCode <= ERR_NONE;
			if (startOk) strokeStop <= 1'b0;
			else if (oppTrip) strokeStop <= 1'b1;
			// count two never reaches the clear state
			deviationClear <= (state_next == ST_CLEAR);
			pulseOut <= mot.pulse;
			directionOut <= mot.direction;
		end
	end
	assign busy = (state_reg != ST_IDLE);

	// ==========================================================
	// checks
	property p_zero_refuse;
		@(posedge core_clk) disable iff (!reset_n)
		zeroRefused |=> errorCode == ERR_ZERO_ON && state_reg == ST_IDLE;
	endproperty
	a_zero_refuse: assert property (p_zero_refuse) else $error("zero-on start not refused");

	property p_clear_end;
		@(posedge core_clk) disable iff (!reset_n)
		$fell(deviationClear) |-> homeDoneFlag && $past(clearCnt_reg) == CLEAR_CYCLES - 1;
	endproperty
	a_clear_end: assert property (p_clear_end) else $error("clear pulse width or done wrong");

	property p_count2_noclear;
		@(posedge core_clk) disable iff (!reset_n)
		method_reg == METHOD_COUNT2 && busy |-> ##1 !deviationClear;
	endproperty
	a_count2_noclear: assert property (p_count2_noclear) else $error("clear in count two");

	property p_start_request;
		@(posedge core_clk) disable iff (!reset_n)
		startOk |=> homeRequestFlag && !homeDoneFlag;
	endproperty
	a_start_request: assert property (p_start_request) else $error("start left request low");

	property p_dog_slow;
		@(posedge core_clk) disable iff (!reset_n)
		state_reg == ST_SEARCH && dog && !oppTrip && !homeTrip |=> state_reg == ST_SLOW;
	endproperty
	a_dog_slow: assert property (p_dog_slow) else $error("dog did not start slowdown");

	property p_stopper_zero;
		@(posedge core_clk) disable iff (!reset_n)
		state_reg == ST_CREEP3 && zero && !oppTrip |=> mot.halt ##1 mot.stopped;
	endproperty
	a_stopper_zero: assert property (p_stopper_zero) else $error("zero did not end run");

	property p_stopper_noretry;
		@(posedge core_clk) disable iff (!reset_n)
		method_reg == METHOD_STOPPER3 |-> state_reg != ST_RETRY_STOP && state_reg != ST_RETRY_REV;
	endproperty
	a_stopper_noretry: assert property (p_stopper_noretry) else $error("retry in stopper");

	property p_stroke;
		@(posedge core_clk) disable iff (!reset_n)
		oppTrip |=> state_reg == ST_STROKE_STOP && strokeStop;
	endproperty
	a_stroke: assert property (p_stroke) else $error("stroke limit ignored");

	property p_ready_loss;
		@(posedge core_clk) disable iff (!reset_n)
		driveReadyOld_reg && !driveReady |=> homeRequestFlag;
	endproperty
	a_ready_loss: assert property (p_ready_loss) else $error("ready loss kept request low");

	c_count1_done: cover property (@(posedge core_clk) disable iff (!reset_n)
		method_reg == METHOD_COUNT1 && $rose(homeDoneFlag));
	c_count2_done: cover property (@(posedge core_clk) disable iff (!reset_n)
		method_reg == METHOD_COUNT2 && $rose(homeDoneFlag));
	c_retry: cover property (@(posedge core_clk) disable iff (!reset_n)
		state_reg == ST_RETRY_REV ##1 state_reg == ST_RETRY_STOP);
	c_stopper_done: cover property (@(posedge core_clk) disable iff (!reset_n)
		method_reg == METHOD_STOPPER3 && $rose(homeDoneFlag));
	c_creep_held: cover property (@(posedge core_clk) state_reg == ST_CREEP3 && mot.atTarget);
endmodule
`default_nettype wire

//--- logic/home_return_pkg.sv
// constants, state codes and timing figures for the home-return sequencer
// assumes a single 10 MHz core clock and that all users import this package
package home_return_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CORE_CLK_HZ = 10_000_000;
	localparam int unsigned CLEAR_TIME_MS = 10;
	localparam int unsigned CLEAR_CYCLES_DEF = CLEAR_TIME_MS * (CORE_CLK_HZ / 1000);
	localparam int unsigned RAMP_TICK_US = 100;
	localparam int unsigned RAMP_TICK_CYCLES = RAMP_TICK_US * (CORE_CLK_HZ / 1_000_000);

	// ==========================================================
	// widths and codes
	localparam int unsigned SPEED_W = 18;
	localparam int unsigned DIST_W = 32;
	localparam int unsigned PHASE_W = 24;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_ZERO_ON = 16'h04B0;

	typedef enum logic [1:0] {
		METHOD_STOPPER3 = 2'h0,
		METHOD_COUNT1 = 2'h1,
		METHOD_COUNT2 = 2'h2
	} method_e;

	// gray codes along the usual path idle-search-slow-wait-clear
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SEARCH = 4'h1,
		ST_SLOW = 4'h3,
		ST_WAIT_ZERO = 4'h2,
		ST_CLEAR = 4'h6,
		ST_DECEL_STOP = 4'h7,
		ST_RETRY_STOP = 4'h5,
		ST_RETRY_REV = 4'h4,
		ST_STROKE_STOP = 4'hC,
		ST_CREEP3 = 4'h8
	} state_e;
endpackage

//--- logic/motion_if.sv
// speed command and status between sequencer and pulse generator
// assumes both ends sit on core_clk
`timescale 1ns/1ps
`default_nettype none
interface motion_if;
	import home_return_pkg::*;
	logic [SPEED_W-1:0] targetSpeed;
	logic [SPEED_W-1:0] biasSpeed;
	logic [SPEED_W-1:0] accelStep;
	logic [SPEED_W-1:0] decelStep;
	logic direction;
	logic halt;
	logic [SPEED_W-1:0] speed;
	logic atTarget;
	logic stopped;
	logic pulse;
	modport seq (output targetSpeed, biasSpeed, accelStep, decelStep, direction, halt,
		input speed, atTarget, stopped, pulse);
	modport gen (input targetSpeed, biasSpeed, accelStep, decelStep, direction, halt,
		output speed, atTarget, stopped, pulse);
endinterface
`default_nettype wire

//--- logic/speed_ramp.sv
// trapezoid speed ramp and pulse-train generator
// assumes steps are per ramp tick and speeds are in pulses per second
`timescale 1ns/1ps
`default_nettype none
module speed_ramp (
	input wire logic core_clk,
	input wire logic reset_n,
	motion_if.gen m
);
	import home_return_pkg::*;

	// ==========================================================
	// ramp tick divider
	logic [15:0] tickCnt_reg;
	logic tick;
	assign tick = (tickCnt_reg == 16'(RAMP_TICK_CYCLES - 1));
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) tickCnt_reg <= '0;
		else tickCnt_reg <= tick ? '0 : tickCnt_reg + 16'h0001;
	end

	// ==========================================================
	// speed update; a start jumps straight to the bias speed, or to the target speed when that is lower
	logic [SPEED_W-1:0] speed_reg, speed_next;
	logic [SPEED_W:0] upSum;
	logic [SPEED_W-1:0] upSpeed, downSpeed, startSpeed;
	assign upSum = {1'b0, speed_reg} + {1'b0, m.accelStep};
	assign upSpeed = (upSum > {1'b0, m.targetSpeed}) ? m.targetSpeed : upSum[SPEED_W-1:0];
	// sum kept one bit wider so a large step cannot wrap the compare
	assign downSpeed = ({1'b0, speed_reg} > {1'b0, m.targetSpeed} + {1'b0, m.decelStep}) ?
		speed_reg - m.decelStep : m.targetSpeed;
	assign startSpeed = (m.biasSpeed < m.targetSpeed) ? m.biasSpeed : m.targetSpeed;
	always_comb begin
		speed_next = speed_reg;
		if (m.halt) speed_next = '0;
		else if (m.targetSpeed == '0 && speed_reg <= m.biasSpeed) speed_next = '0;
		else if (speed_reg < startSpeed) speed_next = startSpeed;
		else if (tick && speed_reg < m.targetSpeed) speed_next = upSpeed;
		else if (tick && speed_reg > m.targetSpeed) speed_next = downSpeed;
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) speed_reg <= '0;
		else speed_reg <= speed_next;
	end

	// ==========================================================
	// phase accumulator: one pulse per CORE_CLK_HZ of accumulated speed
	logic [PHASE_W-1:0] phase_reg;
	logic [PHASE_W-1:0] phaseSum;
	logic pulse_reg;
	logic wrap;
	assign phaseSum = phase_reg + PHASE_W'(speed_reg);
	assign wrap = (phaseSum >= PHASE_W'(CORE_CLK_HZ));
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_reg <= '0;
			pulse_reg <= 1'b0;
		end else begin
			phase_reg <= (speed_reg == '0) ? '0 : (wrap ? phaseSum - PHASE_W'(CORE_CLK_HZ) : phaseSum);
			pulse_reg <= (speed_reg != '0) && wrap;
		end
	end

	assign m.speed = speed_reg;
	assign m.pulse = pulse_reg;
	assign m.stopped = (speed_reg == '0);
	assign m.atTarget = (speed_reg == m.targetSpeed);

	// ==========================================================
	// checks
	property p_halt_zero;
		@(posedge core_clk) disable iff (!reset_n)
		m.halt |=> speed_reg == '0;
	endproperty
	a_halt_zero: assert property (p_halt_zero) else $error("halt did not zero the speed");

	property p_no_pulse_idle;
		@(posedge core_clk) disable iff (!reset_n)
		$past(speed_reg) == '0 |-> !pulse_reg;
	endproperty
	a_no_pulse_idle: assert property (p_no_pulse_idle) else $error("pulse while stopped");
endmodule
`default_nettype wire

//--- verification/axis_model.sv
// behavioural axis behind the sequencer: drive, encoder zero, dog and limit switches
// assumes one position count per core_clk edge with pulseOut high
`timescale 1ns/1ps
`default_nettype none
module axis_model #(
	parameter int DOG_LO = 20,
	parameter int DOG_HI = 60,
	parameter int ZERO_PERIOD = 10,
	parameter int LIM_HOME = 100
) (
	input wire logic core_clk,
	input wire logic pulseOut,
	input wire logic directionOut,
	input wire logic homeDirection,
	input wire logic load,
	input wire logic signed [31:0] loadPos,
	input wire logic forceZero,
	input wire logic oppTrip,
	output logic signed [31:0] pos,
	output logic dogIn,
	output logic zeroIn,
	output logic limitHomeIn,
	output logic limitOppIn
);
	// ==========================================================
	// shaft position, home direction counts upward
	initial pos = 32'sh0;
	always @(posedge core_clk) begin
		if (load) begin
			pos <= loadPos;
		end else if (pulseOut) begin
			pos <= (directionOut == homeDirection) ? pos + 1 : pos - 1;
		end
	end

	// ==========================================================
	// switches; limits are high while clear of the end
	assign dogIn = (pos >= DOG_LO) && (pos <= DOG_HI);
	// encoder index stays on while the shaft rests on it
	assign zeroIn = forceZero || (pos != 0 && pos % ZERO_PERIOD == 0);
	assign limitHomeIn = pos < LIM_HOME;
	assign limitOppIn = !oppTrip && (pos > -LIM_HOME);
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the home-return sequencer with a behavioural axis
// assumes the package and both design modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import home_return_pkg::*;
	localparam int CLR = 20; // short clear pulse keeps the run brief
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic homeStartInstruction = 1'b0;
	method_e methodSel = METHOD_STOPPER3;
	logic limitsSelected = 1'b0;
	logic homeDirection = 1'b1;
	logic [31:0] postDogDistance = 32'h0000_0019;
	logic cpuRun = 1'b1;
	logic driveReadyIn = 1'b1;
	logic load = 1'b0;
	logic signed [31:0] loadPos = 32'sh0;
	logic forceZero = 1'b0;
	logic oppTrip = 1'b0;
	logic signed [31:0] pos;
	logic dogIn, zeroIn, limitHomeIn, limitOppIn;
	logic pulseOut, directionOut, deviationClear, homeDoneFlag, homeRequestFlag, busy;
	logic strokeStop;
	logic [15:0] errorCode;
	int nErrors = 0;
	int compares = 0;

	// ==========================================================
	// clock and watchdog; the watchdog is far beyond the longest expected run
	always #50 core_clk = ~core_clk;
	initial begin
		#9_000_000;
		nErrors++;
		final_report();
	end

	home_return_count_sequencer #(.CLEAR_CYCLES(CLR)) u_home_return_count_sequencer (
		.core_clk(core_clk), .reset_n(reset_n), .homeStartInstruction(homeStartInstruction),
		.methodSel(methodSel), .limitsSelected(limitsSelected), .homeDirection(homeDirection),
		.searchSpeed(18'h30D40), .creepSpeed(18'h0C350), .biasSpeed(18'h186A0),
		.accelStep(18'h30D40), .stopDecelStep(18'h0C350), .postDogDistance(postDogDistance),
		.cpuRun(cpuRun), .dogIn(dogIn), .zeroIn(zeroIn), .limitHomeIn(limitHomeIn),
		.limitOppIn(limitOppIn), .driveReadyIn(driveReadyIn), .pulseOut(pulseOut),
		.directionOut(directionOut), .deviationClear(deviationClear),
		.homeDoneFlag(homeDoneFlag), .homeRequestFlag(homeRequestFlag), .busy(busy),
		.strokeStop(strokeStop), .errorCode(errorCode));

	axis_model u_axis_model (
		.core_clk(core_clk), .pulseOut(pulseOut), .directionOut(directionOut),
		.homeDirection(homeDirection), .load(load), .loadPos(loadPos),
		.forceZero(forceZero), .oppTrip(oppTrip), .pos(pos), .dogIn(dogIn),
		.zeroIn(zeroIn), .limitHomeIn(limitHomeIn), .limitOppIn(limitOppIn));

	// ==========================================================
	// access tasks; inputs always change 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			nErrors++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// place the axis, pick the method, then give a one-cycle start
	task automatic run(input method_e m, input logic lim, input logic signed [31:0] p);
		load = 1'b1;
		loadPos = p;
		methodSel = m;
		limitsSelected = lim;
		step(1);
		load = 1'b0;
		step(4);
		homeStartInstruction = 1'b1;
		step(1);
		homeStartInstruction = 1'b0;
	endtask

	// bounded wait for the run to end, timing the clear pulse meanwhile
	task automatic waitIdle(output int clr);
		clr = 0;
		for (int k = 0; k < 40000 && busy !== 1'b0; k++) begin
			step(1);
			if (deviationClear === 1'b1) clr++;
		end
		check({31'h0, busy}, 32'h0);
	endtask

	task automatic runCase(input method_e m, input logic lim, input logic signed [31:0] p,
			input logic signed [31:0] expPos, input int expClr, input logic chkPos);
		int clr;
		run(m, lim, p);
		waitIdle(clr);
		if (chkPos) check(pos, expPos);
		check(clr, expClr);
		check({31'h0, homeDoneFlag}, 32'h1);
		check({31'h0, homeRequestFlag}, 32'h0);
	endtask

	task automatic final_report();
		if (nErrors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================
	// test sequence
	initial begin
		int clr;
		step(4);
		reset_n = 1'b1;
		check({31'h0, homeRequestFlag}, 32'h1);
		check({29'h0, homeDoneFlag, deviationClear, busy}, 32'h0);
		step(3);
		// zero already on: refused with its error code
		forceZero = 1'b1;
		run(METHOD_STOPPER3, 1'b0, 32'sh1);
		step(2);
		check({16'h0, errorCode}, 32'h4B0);
		check({31'h0, busy}, 32'h0);
		forceZero = 1'b0;
		// stopper: first zero ends the run; method change after start is ignored
		run(METHOD_STOPPER3, 1'b0, 32'sh1);
		methodSel = METHOD_COUNT2;
		step(3);
		check({16'h0, errorCode}, 32'h0);
		check({31'h0, directionOut}, 32'h1);
		waitIdle(clr);
		check(pos, 32'shA);
		check(clr, CLR);
		check({30'h0, homeDoneFlag, homeRequestFlag}, 32'h2);
		// stopper at the home limit keeps going home
		runCase(METHOD_STOPPER3, 1'b1, 32'sh65, 32'sh6E, CLR, 1'b1);
		// count one, compliant distance and one shorter than the slowdown
		runCase(METHOD_COUNT1, 1'b0, 32'sh0, 32'sh32, CLR, 1'b1);
		cpuRun = 1'b0;
		step(4);
		cpuRun = 1'b1;
		step(5);
		check({31'h0, homeRequestFlag}, 32'h1);
		postDogDistance = 32'h0000_0002;
		runCase(METHOD_COUNT1, 1'b0, 32'sh0, 32'sh1E, CLR, 1'b1);
		postDogDistance = 32'h0000_0019;
		// count two: no clear pulse, home past the distance
		runCase(METHOD_COUNT2, 1'b0, 32'sh0, 32'sh0, 0, 1'b0);
		check({31'h0, pos >= 32'sh2D}, 32'h1);
		driveReadyIn = 1'b0;
		step(5);
		check({31'h0, homeRequestFlag}, 32'h1);
		driveReadyIn = 1'b1;
		postDogDistance = 32'h0000_0002;
		runCase(METHOD_COUNT2, 1'b0, 32'sh0, 32'sh0, 0, 1'b0);
		postDogDistance = 32'h0000_0019;
		// retry: start on the dog, and start past it towards the home limit
		run(METHOD_COUNT1, 1'b1, 32'sh1E);
		step(5);
		check({31'h0, directionOut}, 32'h0);
		waitIdle(clr);
		check(pos, 32'sh32);
		check({31'h0, homeDoneFlag}, 32'h1);
		runCase(METHOD_COUNT1, 1'b1, 32'sh46, 32'sh32, CLR, 1'b1);
		// opposite limit trips mid-run: stop without completion
		run(METHOD_COUNT1, 1'b1, 32'sh0);
		step(300);
		oppTrip = 1'b1;
		waitIdle(clr);
		check({30'h0, strokeStop, homeDoneFlag}, 32'h2);
		check(clr, 32'h0);
		oppTrip = 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
